// >>> design/tlic_ctrl.sv
/*
  Two-level interrupt controller with AXI4-Lite registers and a core vector port.
  Assumes event pins are asynchronous, while the core's return strobe and return
  address are on mclk.  The core pushes pushAddr on its stack and jumps to vecAddr.
*/
`timescale 1ns/1ps
`default_nettype none

module tlic_ctrl
  import tlic_pkg::*;
#(
  parameter int NSRC = 8,
  parameter logic [NSRC-1:0] PERIPH_MASK = {{(NSRC/2){1'b1}}, {(NSRC-NSRC/2){1'b0}}}
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire tlic_axi_req_s axiReq,
  output tlic_axi_rsp_s axiRsp,
  input wire logic [NSRC-1:0] srcEvent,
  input wire logic returnFromIsr,
  input wire tlic_pc_t retAddr,
  output tlic_core_s coreOut
);

  localparam int DIV_W = $clog2(MCLK_PER_INSTR);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_PER_INSTR - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_FIRE} tlic_vec_e;

  typedef struct packed {
    tlic_axi_rsp_s rsp;
    tlic_addr_t awAddr;
    tlic_data_t wData;
    logic [3:0] wStrb;
    logic highEn;
    logic lowEn;
    logic prioMode;
    logic [NSRC-1:0] enable;
    logic [NSRC-1:0] prio;
    logic inHigh;
    logic inLow;
    tlic_vec_e phase;
    logic pendHigh;
    logic [DIV_W-1:0] divCnt;
    tlic_core_s core;
  } tlic_ctrl_s;

  tlic_ctrl_s st;
  tlic_ctrl_s next_st;
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] flagClr;
  logic tick;
  logic eligHigh;
  logic eligLow;
  logic [NSRC-1:0] armed;

  function automatic tlic_data_t strbMask(input logic [3:0] s);
    tlic_data_t m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  function automatic logic isMapped(input tlic_addr_t a);
    return (a == OFF_IRQ_CTRL) || (a == OFF_RST_CTRL) || (a == OFF_FLAGS) ||
           (a == OFF_ENABLES) || (a == OFF_PRIO_SEL) || (a == OFF_STATUS);
  endfunction

  // Flag, enable and priority select per source; the flags live in the cells.
  for (genvar g = 0; g < NSRC; g++)
  begin : gSrc
    tlic_src_cell uCell (
      .mclk(mclk),
      .arst_n(arst_n),
      .evtPin(srcEvent[g]),
      .flagClr(flagClr[g]),
      .flag(flags[g])
    );
  end

  assign tick = (st.divCnt == DIV_LAST);
  assign armed = flags & st.enable;

  // Eligibility per level; the priority selects count only in priority mode.
  always_comb
  begin
    if (st.prioMode)
    begin
      eligHigh = st.highEn && |(armed & st.prio);
      eligLow = st.highEn && st.lowEn && !st.inHigh && |(armed & ~st.prio);
    end
    else
    begin
      eligHigh = st.highEn && (|(armed & ~PERIPH_MASK) ||
                 (st.lowEn && |(armed & PERIPH_MASK)));
      eligLow = 1'b0;
    end
  end

  // Flags clear when software writes ones to them; a new event still wins.
  always_comb
  begin
    tlic_data_t fm;
    fm = strbMask(st.wStrb);
    flagClr = '0;
    if (!st.rsp.awready && !st.rsp.wready && !st.rsp.bvalid && st.awAddr == OFF_FLAGS)
    begin
      flagClr = st.wData[NSRC-1:0] & fm[NSRC-1:0];
    end
  end

  always_comb
  begin
    tlic_data_t m;
    tlic_data_t rd;
    m = strbMask(st.wStrb);
    rd = '0;
    next_st = st;
    next_st.core.vecLoad = 1'b0;
    next_st.divCnt = tick ? '0 : DIV_W'(st.divCnt + 1'b1);

    if (axiReq.awvalid && st.rsp.awready)
    begin
      next_st.awAddr = axiReq.awaddr;
      next_st.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && st.rsp.wready)
    begin
      next_st.wData = axiReq.wdata;
      next_st.wStrb = axiReq.wstrb;
      next_st.rsp.wready = 1'b0;
    end
    if (!st.rsp.awready && !st.rsp.wready && !st.rsp.bvalid)
    begin
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = isMapped(st.awAddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (st.awAddr)
        OFF_IRQ_CTRL:
        begin
          if (st.wStrb[0])
          begin
            next_st.highEn = st.wData[CTRL_HIGH_BIT];
            next_st.lowEn = st.wData[CTRL_LOW_BIT];
          end
        end
        OFF_RST_CTRL:
        begin
          if (st.wStrb[0])
          begin
            next_st.prioMode = st.wData[RST_PRIO_BIT];
          end
        end
        OFF_ENABLES:
        begin
          next_st.enable = (st.enable & ~m[NSRC-1:0]) | (st.wData[NSRC-1:0] & m[NSRC-1:0]);
        end
        OFF_PRIO_SEL:
        begin
          next_st.prio = (st.prio & ~m[NSRC-1:0]) | (st.wData[NSRC-1:0] & m[NSRC-1:0]);
        end
        default:
        begin
        end
      endcase
    end
    if (st.rsp.bvalid && axiReq.bready)
    begin
      next_st.rsp.bvalid = 1'b0;
      next_st.rsp.awready = 1'b1;
      next_st.rsp.wready = 1'b1;
    end

    if (axiReq.arvalid && st.rsp.arready)
    begin
      unique case (axiReq.araddr)
        OFF_IRQ_CTRL:
        begin
          rd[CTRL_HIGH_BIT] = st.highEn;
          rd[CTRL_LOW_BIT] = st.lowEn;
        end
        OFF_RST_CTRL: rd[RST_PRIO_BIT] = st.prioMode;
        OFF_FLAGS: rd[NSRC-1:0] = flags;
        OFF_ENABLES: rd[NSRC-1:0] = st.enable;
        OFF_PRIO_SEL: rd[NSRC-1:0] = st.prio;
        OFF_STATUS:
        begin
          rd[STAT_IN_HIGH_BIT] = st.inHigh;
          rd[STAT_IN_LOW_BIT] = st.inLow;
          rd[STAT_BUSY_BIT] = (st.phase != ST_IDLE);
        end
        default: rd = '0;
      endcase
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rd;
      next_st.rsp.rresp = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rsp.rvalid && axiReq.rready)
    begin
      next_st.rsp.rvalid = 1'b0;
      next_st.rsp.arready = 1'b1;
    end

    // Leaving a routine restores the enable of the level that was running.
    if (returnFromIsr)
    begin
      if (st.inHigh)
      begin
        next_st.inHigh = 1'b0;
        next_st.highEn = 1'b1;
      end
      else if (st.inLow)
      begin
        next_st.inLow = 1'b0;
        next_st.lowEn = 1'b1;
      end
    end

    // Requests are sampled on instruction-cycle boundaries and vector two
    // boundaries later, so the latency never depends on the running instruction.
    if (tick)
    begin
      unique case (st.phase)
        ST_IDLE:
        begin
          if (eligHigh && !st.inHigh)
          begin
            next_st.pendHigh = 1'b1;
            next_st.highEn = 1'b0;
            next_st.phase = ST_ARM;
          end
          else if (eligLow && !st.inLow)
          begin
            next_st.pendHigh = 1'b0;
            next_st.lowEn = 1'b0;
            next_st.phase = ST_ARM;
          end
        end
        ST_ARM: next_st.phase = ST_FIRE;
        ST_FIRE:
        begin
          next_st.core.vecLoad = 1'b1;
          next_st.core.vecAddr = st.pendHigh ? VEC_HIGH : VEC_LOW;
          next_st.core.pushAddr = retAddr;
          // A return in the same cycle has already updated next_st and must not be undone.
          next_st.inHigh = next_st.inHigh | st.pendHigh;
          next_st.inLow = next_st.inLow | !st.pendHigh;
          next_st.phase = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.rsp.awready <= 1'b1;
      st.rsp.wready <= 1'b1;
      st.rsp.arready <= 1'b1;
      st.highEn <= CTRL_HIGH_RESET;
      st.lowEn <= CTRL_LOW_RESET;
      st.prioMode <= PRIO_MODE_RESET;
      st.phase <= ST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign axiRsp = st.rsp;
  assign coreOut = st.core;

  default clocking cbMain @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_vecLevel;
    coreOut.vecLoad |-> ((coreOut.vecAddr == VEC_HIGH && st.inHigh && !$past(st.inHigh)) ||
                         (coreOut.vecAddr == VEC_LOW && st.inLow && !$past(st.inLow)));
  endproperty
  a_vecLevel: assert property (p_vecLevel) else $error("vector does not match level");

  property p_compatVec;
    (coreOut.vecLoad && !st.prioMode && !$past(st.prioMode, 9)) |-> coreOut.vecAddr == VEC_HIGH;
  endproperty
  a_compatVec: assert property (p_compatVec) else $error("compatibility vector not 0008h");

  property p_preempt;
    (tick && st.phase == ST_IDLE && st.inLow && !st.inHigh && eligHigh) |=> (st.phase == ST_ARM && st.pendHigh);
  endproperty
  a_preempt: assert property (p_preempt) else $error("high did not preempt low routine");

  property p_highFirst;
    (tick && st.phase == ST_IDLE && eligHigh && eligLow && !st.inHigh) |=> st.pendHigh;
  endproperty
  a_highFirst: assert property (p_highFirst) else $error("low taken before high");

  property p_accept;
    (tick && st.phase == ST_IDLE && eligHigh && !st.inHigh) |=> (st.phase == ST_ARM && !st.highEn);
  endproperty
  a_accept: assert property (p_accept) else $error("eligible request not accepted");

  property p_blockedOff;
    (tick && st.phase == ST_IDLE && !st.highEn) |=> st.phase == ST_IDLE;
  endproperty
  a_blockedOff: assert property (p_blockedOff) else $error("accepted with global enable off");

  property p_lowBlocked;
    (tick && st.phase == ST_IDLE && (st.inHigh || !st.lowEn)) |=> !(st.phase == ST_ARM && !st.pendHigh);
  endproperty
  a_lowBlocked: assert property (p_lowBlocked) else $error("low accepted while blocked");

  property p_latency;
    (st.phase == ST_ARM && $past(st.phase) == ST_IDLE) |-> ##8 coreOut.vecLoad;
  endproperty
  a_latency: assert property (p_latency) else $error("vector latency not fixed");

  property p_push;
    coreOut.vecLoad |-> coreOut.pushAddr == $past(retAddr);
  endproperty
  a_push: assert property (p_push) else $error("return address not pushed");

  property p_restore;
    (returnFromIsr && st.inHigh) |=> (st.highEn && !st.inHigh);
  endproperty
  a_restore: assert property (p_restore) else $error("return did not restore enable");

  c_highVec: cover property (coreOut.vecLoad && coreOut.vecAddr == VEC_HIGH);
  c_lowVec: cover property (coreOut.vecLoad && coreOut.vecAddr == VEC_LOW);
  c_preempt: cover property (tick && st.phase == ST_IDLE && st.inLow && eligHigh);
  c_slvErr: cover property (st.rsp.bvalid && st.rsp.bresp == RESP_SLVERR);

endmodule

`default_nettype wire

// >>> design/tlic_pkg.sv
/*
  Shared constants and carrier types for the two-level interrupt controller.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address and a core
  that consumes a vector strobe with a 16-bit vector and return address.
*/
package tlic_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int PC_W = 16;

  typedef logic [AXI_AW-1:0] tlic_addr_t;
  typedef logic [AXI_DW-1:0] tlic_data_t;
  typedef logic [PC_W-1:0] tlic_pc_t;

  localparam tlic_addr_t OFF_IRQ_CTRL = 8'h00;
  localparam tlic_addr_t OFF_RST_CTRL = 8'h04;
  localparam tlic_addr_t OFF_FLAGS = 8'h08;
  localparam tlic_addr_t OFF_ENABLES = 8'h0C;
  localparam tlic_addr_t OFF_PRIO_SEL = 8'h10;
  localparam tlic_addr_t OFF_STATUS = 8'h14;

  localparam int CTRL_HIGH_BIT = 7;
  localparam int CTRL_LOW_BIT = 6;
  localparam int RST_PRIO_BIT = 7;
  localparam int STAT_IN_HIGH_BIT = 0;
  localparam int STAT_IN_LOW_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  localparam logic CTRL_HIGH_RESET = 1'b0;
  localparam logic CTRL_LOW_RESET = 1'b0;
  localparam logic PRIO_MODE_RESET = 1'b0;

  localparam tlic_pc_t VEC_HIGH = 16'h0008;
  localparam tlic_pc_t VEC_LOW = 16'h0018;

  localparam int MCLK_PER_INSTR = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    tlic_addr_t awaddr;
    logic wvalid;
    tlic_data_t wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    tlic_addr_t araddr;
    logic rready;
  } tlic_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    tlic_data_t rdata;
    logic [1:0] rresp;
  } tlic_axi_rsp_s;

  typedef struct packed {
    logic vecLoad;
    tlic_pc_t vecAddr;
    tlic_pc_t pushAddr;
  } tlic_core_s;

endpackage

// >>> design/tlic_src_cell.sv
/*
  One interrupt source: synchronises the event pin and keeps its sticky flag.
  Assumes the event pin is asynchronous to mclk and the clear mask comes from
  logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tlic_src_cell
  import tlic_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic evtPin,
  input wire logic flagClr,
  output logic flag
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic flag;
  } tlic_cell_s;

  tlic_cell_s st;
  tlic_cell_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.sync1 = evtPin;
    next_st.sync2 = st.sync1;
    // The event sets the flag whatever the enables say, and beats a clear.
    next_st.flag = (st.flag & ~flagClr) | st.sync2;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

  property p_flagSets;
    @(posedge mclk) disable iff (!arst_n)
    st.sync2 |=> st.flag;
  endproperty
  a_flagSets: assert property (p_flagSets) else $error("event did not set its flag");

endmodule

`default_nettype wire

// >>> verification/tlic_core_model.sv
/*
  Core-side partner: takes vector strobes, keeps a stack depth, issues returns.
  Assumes the bench asks for a return with a one-cycle retReq pulse on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tlic_core_model
  import tlic_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire tlic_core_s coreOut,
  input wire logic retReq,
  output logic returnFromIsr,
  output tlic_pc_t retAddr
);
  logic [1:0] depth;
  logic doRet;

  assign doRet = retReq && (depth != 2'h0);

  // The program counter moves every cycle so that a stale push address is caught.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      retAddr <= 16'h0100;
      returnFromIsr <= 1'b0;
      depth <= 2'h0;
    end
    else
    begin
      retAddr <= coreOut.vecLoad ? coreOut.vecAddr : retAddr + 16'h0001;
      returnFromIsr <= doRet;
      depth <= depth + {1'b0, coreOut.vecLoad} - {1'b0, doRet};
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
/*
  Self-checking bench for the interrupt controller: register bus, sources, core.
  Assumes the core partner model and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tlic_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  tlic_axi_req_s req = '0;
  tlic_axi_rsp_s rsp;
  tlic_core_s core;
  logic [7:0] srcEvent = 8'h00;
  logic retReq = 1'b0;
  logic returnFromIsr;
  tlic_pc_t retAddr;
  tlic_pc_t prevRet = '0;
  tlic_pc_t expQ[$];
  int err_total = 0;
  int tests_run = 0;
  tlic_data_t rnd;

  always #2 mclk = ~mclk;

  tlic_ctrl tlic_ctrl_i (.mclk(mclk), .arst_n(arst_n), .axiReq(req), .axiRsp(rsp), .srcEvent(srcEvent),
    .returnFromIsr(returnFromIsr), .retAddr(retAddr), .coreOut(core));
  tlic_core_model tlic_core_model_i (.mclk(mclk), .arst_n(arst_n), .coreOut(core), .retReq(retReq),
    .returnFromIsr(returnFromIsr), .retAddr(retAddr));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input tlic_addr_t a, input tlic_data_t d, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        req.bready <= 1'b0;
        done = 1;
        check("bresp", 32'(rsp.bresp), 32'(er));
      end
    end
    check("write done", 32'(done), 32'h1);
    if (!done)
      end_sim();
  endtask

  task automatic rd(input tlic_addr_t a, input tlic_data_t ed, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        req.rready <= 1'b0;
        done = 1;
        check("rdata", rsp.rdata, ed);
        check("rresp", 32'(rsp.rresp), 32'(er));
      end
    end
    check("read done", 32'(done), 32'h1);
    if (!done)
      end_sim();
  endtask

  // Raises the event pins for a random few cycles, then watches for the vector.
  task automatic fire(input logic [7:0] m, input bit exp, input tlic_pc_t va);
    int hold;
    bit seen;
    hold = 3 + $urandom % 4;
    seen = 0;
    if (exp)
      expQ.push_back(va);
    @(posedge mclk);
    srcEvent <= m;
    for (int n = 1; n <= 40; n++)
    begin
      @(posedge mclk);
      if (n == hold)
        srcEvent <= 8'h00;
      if (core.vecLoad && !seen)
        check("latency", 32'(n >= 12 && n <= 16), 32'(exp));
      seen |= core.vecLoad;
    end
    check("vector taken", 32'(seen), 32'(exp));
  endtask

  task automatic ret();
    @(posedge mclk);
    retReq <= 1'b1;
    @(posedge mclk);
    retReq <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // Each vector strobe is matched against the oldest expected vector.
  always @(posedge mclk)
  begin
    if (core.vecLoad)
    begin
      check("vector expected", 32'(expQ.size() > 0), 32'h1);
      if (expQ.size() > 0)
        check("vecAddr", 32'(core.vecAddr), 32'(expQ.pop_front()));
      check("pushAddr", 32'(core.pushAddr), 32'(prevRet));
    end
    prevRet <= retAddr;
  end

  initial
  begin
    void'($urandom(75));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(tlic_addr_t'(i * 4), '0, RESP_OKAY);
    rd(8'h18, '0, RESP_SLVERR);
    wr(8'h18, 32'hFFFFFFFF, RESP_SLVERR);
    rnd = $urandom;
    wr(OFF_PRIO_SEL, rnd, RESP_OKAY);
    rd(OFF_PRIO_SEL, {24'h0, rnd[7:0]}, RESP_OKAY);
    wr(OFF_PRIO_SEL, '0, RESP_OKAY);
    fire(8'h01, 0, '0);
    rd(OFF_FLAGS, 32'h1, RESP_OKAY);
    wr(OFF_FLAGS, 32'h1, RESP_OKAY);
    rd(OFF_FLAGS, '0, RESP_OKAY);
    wr(OFF_ENABLES, 32'h11, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'h80, RESP_OKAY);
    fire(8'h01, 1, VEC_HIGH);
    rd(OFF_IRQ_CTRL, '0, RESP_OKAY);
    rd(OFF_STATUS, 32'h1, RESP_OKAY);
    wr(OFF_FLAGS, 32'h1, RESP_OKAY);
    ret();
    rd(OFF_IRQ_CTRL, 32'h80, RESP_OKAY);
    fire(8'h10, 0, '0);
    wr(OFF_FLAGS, 32'h10, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'hC0, RESP_OKAY);
    fire(8'h10, 1, VEC_HIGH);
    wr(OFF_FLAGS, 32'h10, RESP_OKAY);
    ret();
    wr(OFF_IRQ_CTRL, 32'h40, RESP_OKAY);
    fire(8'h11, 0, '0);
    wr(OFF_FLAGS, 32'h11, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'h80, RESP_OKAY);
    wr(OFF_ENABLES, 32'h10, RESP_OKAY);
    fire(8'h01, 0, '0);
    wr(OFF_FLAGS, 32'h1, RESP_OKAY);
    wr(OFF_IRQ_CTRL, '0, RESP_OKAY);
    wr(OFF_RST_CTRL, 32'h80, RESP_OKAY);
    rd(OFF_RST_CTRL, 32'h80, RESP_OKAY);
    wr(OFF_ENABLES, 32'h03, RESP_OKAY);
    wr(OFF_PRIO_SEL, 32'h02, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'h40, RESP_OKAY);
    fire(8'h03, 0, '0);
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'hC0, RESP_OKAY);
    fire(8'h01, 1, VEC_LOW);
    rd(OFF_IRQ_CTRL, 32'h80, RESP_OKAY);
    fire(8'h02, 1, VEC_HIGH);
    rd(OFF_IRQ_CTRL, '0, RESP_OKAY);
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'hC0, RESP_OKAY);
    fire(8'h01, 0, '0);
    wr(OFF_FLAGS, 32'h1, RESP_OKAY);
    wr(OFF_IRQ_CTRL, '0, RESP_OKAY);
    ret();
    rd(OFF_IRQ_CTRL, 32'h80, RESP_OKAY);
    ret();
    rd(OFF_IRQ_CTRL, 32'hC0, RESP_OKAY);
    rd(OFF_STATUS, '0, RESP_OKAY);
    fire(8'h03, 1, VEC_HIGH);
    expQ.push_back(VEC_LOW);
    wr(OFF_FLAGS, 32'h2, RESP_OKAY);
    ret();
    repeat (30) @(posedge mclk);
    wr(OFF_FLAGS, 32'h1, RESP_OKAY);
    ret();
    check("vectors left", expQ.size(), 32'h0);
    // A second reset in mid-run must bring back compatibility mode and closed enables.
    arst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(OFF_RST_CTRL, '0, RESP_OKAY);
    rd(OFF_IRQ_CTRL, '0, RESP_OKAY);
    rd(OFF_ENABLES, '0, RESP_OKAY);
    fire(8'h01, 0, '0);
    rd(OFF_FLAGS, 32'h1, RESP_OKAY);
    end_sim();
  end
endmodule
`default_nettype wire
